// ===== hdl/cisx_exec.sv
// Executor for a subset of an 8-bit core's instructions, APB controlled
// How it works
// - Interrupt entry pushes only return PC; W and status untouched
// - Set tested bit discards next instruction; a NOP fills, two cycles
// - Watchdog clear zeroes counter, prescaler; sets timeout, power-down
// - Call pushes PC+1, loads 11-bit target, latch bits 4:3 fill top
// - Complement inverts register, d selects W or register, updates zero
// - Register clear writes zero into register and sets zero flag
// - Working clear zeroes W, sets zero flag, no other status change
// - Decrement subtracts one, d selects W or register, updates zero
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module cisx_exec
    import cisx_pkg::*;
#(
    parameter int STACK_D = CISX_STACK_D
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Core status
    output logic             o_busy
);

    // Refuse stack depths that the wrapping pointer cannot serve
    if (STACK_D < 2 || STACK_D > 16
        || (STACK_D & (STACK_D - 1)) != 0) begin : g_bad_depth
        $error("cisx_exec: STACK_D out of range");
    end

    localparam int SPW = $clog2(STACK_D);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cisx_state_type  state_q;
    logic [13:0]     instr_q;
    logic            go_q;         // Instruction pending
    logic            rd_wait_q;    // Operand fetch in progress
    logic [7:0]      w_q;
    logic [7:0]      status_q;
    logic [12:0]     pc_q;
    logic [7:0]      latch_q;
    logic [7:0]      watchdog_counter_q;
    logic [7:0]      presc_q;
    logic [12:0]     stack_q [0:STACK_D-1];
    logic [SPW-1:0]  sp_q;
    logic [6:0]      faddr_q;
    logic [7:0]      fdata;
    logic            ram_we;
    logic [6:0]      ram_waddr;
    logic [7:0]      ram_wdata;
    logic [6:0]      ram_raddr;

    // APB decode
    logic apb_wr;
    logic mapped;
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign mapped = (i_paddr <= CISX_OFF_SP) && (i_paddr[1:0] == 2'b00);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // Instruction field decode
    logic [6:0] f_addr;
    logic       dbit;
    logic [2:0] bsel;
    logic       is_btss, is_call, is_cpl, is_decr, is_fclr, is_wclr, is_wdog;
    assign f_addr  = instr_q[6:0];
    assign dbit    = instr_q[7];
    assign bsel    = instr_q[9:7];
    assign is_btss = instr_q[13:10] == CISX_OP_BTSS;
    assign is_call = instr_q[13:11] == CISX_OP_CALL;
    assign is_cpl  = instr_q[13:8] == CISX_OP_CPL;
    assign is_decr = instr_q[13:8] == CISX_OP_DECR;
    assign is_fclr = (instr_q[13:8] == CISX_OP_CLEAR) && dbit;
    assign is_wclr = (instr_q[13:8] == CISX_OP_CLEAR) && !dbit;
    assign is_wdog = instr_q == CISX_WATCHDOG_CLR;

    logic needs_f;
    logic exec_now;
    logic irq_req;
    assign needs_f  = is_btss || is_cpl || is_decr;
    assign exec_now = go_q && (state_q == CISX_S_EXEC)
                      && (!needs_f || rd_wait_q);
    assign irq_req  = apb_wr && mapped && (i_paddr == CISX_OFF_CTRL)
                      && i_pwdata[CISX_CTRL_IRQ];
    assign o_busy   = go_q || (state_q != CISX_S_EXEC);

    // ALU result for complement and decrement
    logic [7:0] alu;
    always_comb begin
        alu = is_cpl ? ~fdata : 8'(fdata - 8'h01);
    end

    // ------------------------------------------------------------------
    // Register file memory
    // ------------------------------------------------------------------
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = faddr_q;
        ram_wdata = i_pwdata[7:0];
        ram_raddr = go_q ? f_addr : faddr_q;
        if (exec_now && is_fclr) begin
            ram_we    = 1'b1;
            ram_waddr = f_addr;
            ram_wdata = 8'h00;
        end else if (exec_now && (is_cpl || is_decr) && dbit) begin
            ram_we    = 1'b1;
            ram_waddr = f_addr;
            ram_wdata = alu;
        end else if (apb_wr && i_paddr == CISX_OFF_FDATA && !o_busy) begin
            ram_we    = 1'b1;
        end
    end

    cisx_ram #(.AW(CISX_FILE_W), .DW(8)) u_ram (
        .i_clock (i_clock),
        .i_we    (ram_we),
        .i_waddr (ram_waddr),
        .i_wdata (ram_wdata),
        .i_raddr (ram_raddr),
        .o_rdata (fdata)
    );

    // ------------------------------------------------------------------
    // Sequencer and operand fetch
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q   <= CISX_S_EXEC;
            go_q      <= 1'b0;
            rd_wait_q <= 1'b0;
            instr_q   <= 14'h0000;
        end else begin
            rd_wait_q <= go_q && needs_f && !rd_wait_q;
            unique case (state_q)
                CISX_S_EXEC: begin
                    if (exec_now) begin
                        go_q <= 1'b0;
                        if (is_btss && fdata[bsel]) begin
                            state_q <= CISX_S_NOP;
                        end else if (is_call) begin
                            state_q <= CISX_S_CALL;
                        end
                    end else if (!go_q && apb_wr
                                 && i_paddr == CISX_OFF_INSTR) begin
                        instr_q <= i_pwdata[13:0];
                        go_q    <= 1'b1;
                    end
                end
                CISX_S_NOP:  state_q <= CISX_S_EXEC;
                CISX_S_CALL: state_q <= CISX_S_EXEC;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Program counter and stack
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pc_q <= CISX_PC_RST;
            sp_q <= '0;
        end else if (irq_req && !o_busy) begin
            stack_q[sp_q] <= pc_q;
            sp_q          <= SPW'(sp_q + 1'b1);
            pc_q          <= CISX_IRQ_VECTOR;
        end else if (exec_now && is_call) begin
            stack_q[sp_q] <= 13'(pc_q + 13'h0001);
            sp_q          <= SPW'(sp_q + 1'b1);
            pc_q <= {latch_q[CISX_LATCH_LO+1:CISX_LATCH_LO], instr_q[10:0]};
        end else if (exec_now) begin
            pc_q <= 13'(pc_q + 13'h0001);
        end else if (state_q == CISX_S_NOP) begin
            pc_q <= 13'(pc_q + 13'h0001);
        end else if (apb_wr && i_paddr == CISX_OFF_PC && !o_busy) begin
            pc_q <= i_pwdata[12:0];
        end
    end

    // ------------------------------------------------------------------
    // Working register and status
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            w_q      <= 8'h00;
            status_q <= CISX_STATUS_RST;
        end else if (exec_now) begin
            if (is_wclr) begin
                w_q <= 8'h00;
                status_q[CISX_ST_ZERO] <= 1'b1;
            end else if (is_fclr) begin
                status_q[CISX_ST_ZERO] <= 1'b1;
            end else if (is_cpl || is_decr) begin
                if (!dbit) begin
                    w_q <= alu;
                end
                status_q[CISX_ST_ZERO] <= (alu == 8'h00);
            end else if (is_wdog) begin
                status_q[CISX_ST_TIMEOUT] <= 1'b1;
                status_q[CISX_ST_PDOWN]   <= 1'b1;
            end
        end else if (apb_wr && !o_busy) begin
            if (i_paddr == CISX_OFF_WREG) begin
                w_q <= i_pwdata[7:0];
            end
            if (i_paddr == CISX_OFF_STATUS) begin
                status_q <= i_pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Latch, file address, watchdog counter and prescaler
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            latch_q <= 8'h00;
            faddr_q <= 7'h00;
        end else if (apb_wr && !o_busy) begin
            if (i_paddr == CISX_OFF_LATCH) begin
                latch_q <= i_pwdata[7:0];
            end
            if (i_paddr == CISX_OFF_FADDR) begin
                faddr_q <= i_pwdata[6:0];
            end
        end
    end

    // Watchdog advances once every 256 cycles through the prescaler
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            watchdog_counter_q <= 8'h00;
            presc_q            <= 8'h00;
        end else if (exec_now && is_wdog) begin
            watchdog_counter_q <= 8'h00;
            presc_q            <= 8'h00;
        end else begin
            presc_q <= 8'(presc_q + 8'h01);
            if (presc_q == 8'hFF) begin
                watchdog_counter_q <= 8'(watchdog_counter_q + 8'h01);
            end
        end
    end

    // ------------------------------------------------------------------
    // APB read data, registered in the setup phase
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
                CISX_OFF_CTRL:   o_prdata <= {31'h0, o_busy};
                CISX_OFF_INSTR:  o_prdata <= {18'h0, instr_q};
                CISX_OFF_WREG:   o_prdata <= {24'h0, w_q};
                CISX_OFF_STATUS: o_prdata <= {24'h0, status_q};
                CISX_OFF_PC:     o_prdata <= {19'h0, pc_q};
                CISX_OFF_LATCH:  o_prdata <= {24'h0, latch_q};
                CISX_OFF_STACK_TOP:
                    o_prdata <= {19'h0, stack_q[SPW'(sp_q - 1'b1)]};
                CISX_OFF_WATCHDOG:
                    o_prdata <= {16'h0, presc_q, watchdog_counter_q};
                CISX_OFF_FADDR:  o_prdata <= {25'h0, faddr_q};
                CISX_OFF_FDATA:  o_prdata <= {24'h0, fdata};
                CISX_OFF_SP:     o_prdata <= {{(32-SPW){1'b0}}, sp_q};
                default:         o_prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // cisx_exec

// ===== hdl/cisx_pkg.sv
// Package of constants and types for the instruction subset executor
package cisx_pkg;

    // ------------------------------------------------------------------
    // Register offsets (word aligned byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [11:0] CISX_OFF_CTRL   = 12'h000;
    localparam logic [11:0] CISX_OFF_INSTR  = 12'h004;
    localparam logic [11:0] CISX_OFF_WREG   = 12'h008;
    localparam logic [11:0] CISX_OFF_STATUS = 12'h00C;
    localparam logic [11:0] CISX_OFF_PC     = 12'h010;
    localparam logic [11:0] CISX_OFF_LATCH  = 12'h014;
    localparam logic [11:0] CISX_OFF_STACK_TOP = 12'h018;
    localparam logic [11:0] CISX_OFF_WATCHDOG  = 12'h01C;
    localparam logic [11:0] CISX_OFF_FADDR  = 12'h020;
    localparam logic [11:0] CISX_OFF_FDATA  = 12'h024;
    localparam logic [11:0] CISX_OFF_SP     = 12'h028;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CISX_ST_ZERO     = 2;
    localparam int CISX_ST_PDOWN    = 3;
    localparam int CISX_ST_TIMEOUT  = 4;
    localparam int CISX_CTRL_IRQ    = 0;
    localparam int CISX_LATCH_LO    = 3;
    localparam logic [7:0]  CISX_STATUS_RST = 8'h18;
    localparam logic [12:0] CISX_PC_RST     = 13'h0000;
    localparam logic [12:0] CISX_IRQ_VECTOR = 13'h0004;
    localparam int CISX_PC_W      = 13;
    localparam int CISX_FILE_W    = 7;
    localparam int CISX_STACK_D   = 8;

    // ------------------------------------------------------------------
    // Opcode fields of the 14-bit instruction word
    // ------------------------------------------------------------------
    localparam logic [5:0] CISX_OP_CLEAR = 6'h01; // d picks working or file
    localparam logic [5:0] CISX_OP_DECR  = 6'h03;
    localparam logic [5:0] CISX_OP_CPL   = 6'h09;
    localparam logic [3:0] CISX_OP_BTSS  = 4'h7;
    localparam logic [2:0] CISX_OP_CALL  = 3'h4;
    localparam logic [13:0] CISX_WATCHDOG_CLR = 14'h0064;

    // Sequencer states
    typedef enum logic [2:0] {
        CISX_S_EXEC = 3'b001,
        CISX_S_NOP  = 3'b010,
        CISX_S_CALL = 3'b100
    } cisx_state_type;

endpackage : cisx_pkg

// ===== hdl/cisx_ram.sv
// Register file memory with registered read data
`timescale 1ns/1ps
module cisx_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock
    input  wire logic          i_clock,
    // Write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    // Read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);

    // Refuse sizes the memory array cannot hold
    if (AW < 1 || AW > 12 || DW < 1) begin : g_bad_size
        $error("cisx_ram: AW or DW out of range");
    end

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // Write and registered read
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end

endmodule // cisx_ram

// ===== tb/cisx_exec_monitor.sv
// Checker of port behaviour for the instruction subset executor
`timescale 1ns/1ps
module cisx_exec_monitor (
    // Clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst,
    // APB slave side
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Core status
    input wire logic        o_busy
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // -----------------------------------------------------------------
    // Bus phases
    // -----------------------------------------------------------------
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_access;
        i_psel && i_penable;
    endsequence
    logic bad_addr;
    assign bad_addr = (i_paddr > 12'h028) || (i_paddr[1:0] != 2'h0);
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    a_ready_zero_wait: assert property (s_access |-> o_pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (s_access and bad_addr |-> o_pslverr)
        else $error("no error on unmapped access");
    a_mapped_no_err: assert property (s_access and !bad_addr |-> !o_pslverr)
        else $error("error on mapped access");
    a_idle_no_err: assert property (!(i_psel && i_penable) |-> !o_pslverr)
        else $error("error outside access phase");
    a_unmapped_reads_zero: assert property (
        s_setup and !i_pwrite && bad_addr |=> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data changed without read");
    a_instr_starts_busy: assert property (s_access and i_pwrite
        && i_paddr == 12'h004 && !o_busy |=> o_busy)
        else $error("instruction write did not start");
    a_busy_bounded: assert property (
        $rose(o_busy) |-> ##[1:6] !o_busy)
        else $error("instruction did not finish in time");
    a_busy_read_back: assert property (s_setup and !i_pwrite
        && i_paddr == 12'h000 |=> o_prdata[0] == $past(o_busy))
        else $error("busy bit read back wrong");
endmodule // cisx_exec_monitor

bind cisx_exec cisx_exec_monitor i_mon (.i_clock(i_clock), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy));

// ===== tb/testbench.sv
// Self-checking bench of the instruction subset executor
`timescale 1ns/1ps
module testbench;
    import cisx_pkg::*;
    logic        i_clock, i_rst, i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rv;
    logic        o_pready, o_pslverr, o_busy, rerr;
    logic [15:0] lf;
    logic [7:0]  v, w0, st, res, lat;
    logic [12:0] p;
    logic [6:0]  f;
    logic [5:0]  op;
    int          n_mismatch, num_checks, cyc;
    cisx_exec i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_busy(o_busy));
    // Clock and hang guard
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] alu(input logic [5:0] o,
                                       input logic [7:0] a);
        return (o == CISX_OP_CPL) ? ~a : a - 8'h01;
    endfunction
    task automatic rnd();
        lf = lfsr_next(lf);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch = n_mismatch + 1;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        rv = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input string nm,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rv);
    endtask
    task automatic exec(input logic [13:0] ins, input logic irq);
        int n;
        if (irq) apb(1'b1, CISX_OFF_CTRL, 32'h1);
        else apb(1'b1, CISX_OFF_INSTR, {18'h0, ins});
        n = 0;
        do begin
            apb(1'b0, CISX_OFF_CTRL, 32'h0);
            n = n + 1;
        end while (rv[0] !== 1'b0 && n < 20);
        chk("busy", 32'h0, {31'h0, rv[0]});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {i_rst, i_psel, i_penable, i_pwrite} = 4'h8;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        lf = 16'h003B;
        n_mismatch = 0;
        num_checks = 0;
        cyc = 0;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(CISX_OFF_STATUS, "status rst", {24'h0, CISX_STATUS_RST});
        rd(CISX_OFF_PC, "pc rst", 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped rd", 32'h0, rv);
        // Complement and decrement, both destinations, corners then random
        for (int i = 0; i < 12; i++) begin
            rnd();
            op = i[0] ? CISX_OP_CPL : CISX_OP_DECR;
            v = (i < 4) ? (i[0] ? 8'hFF : 8'h01) : lf[7:0];
            f = lf[14:8];
            w0 = lf[15:8] ^ 8'h5A;
            apb(1'b1, CISX_OFF_FADDR, {25'h0, f});
            apb(1'b1, CISX_OFF_FDATA, {24'h0, v});
            apb(1'b1, CISX_OFF_WREG, {24'h0, w0});
            exec({op, i[1], f}, 1'b0);
            res = alu(op, v);
            rd(CISX_OFF_WREG, "w", {24'h0, i[1] ? w0 : res});
            rd(CISX_OFF_FDATA, "f", {24'h0, i[1] ? res : v});
            apb(1'b0, CISX_OFF_STATUS, 32'h0);
            chk("zero", {31'h0, res == 8'h0},
                {31'h0, rv[CISX_ST_ZERO]});
            chk("status keep", {24'h0, CISX_STATUS_RST & 8'hFB},
                rv & 32'hFFFF_FFFB);
        end
        // Register clear and working clear
        apb(1'b1, CISX_OFF_FDATA, 32'h3C);
        apb(1'b1, CISX_OFF_STATUS, 32'h0);
        exec({CISX_OP_CLEAR, 1'b1, f}, 1'b0);
        rd(CISX_OFF_FDATA, "clr f", 32'h0);
        apb(1'b0, CISX_OFF_STATUS, 32'h0);
        chk("clr z", 32'h1, {31'h0, rv[CISX_ST_ZERO]});
        apb(1'b1, CISX_OFF_STATUS, 32'h0);
        apb(1'b1, CISX_OFF_WREG, 32'hA5);
        exec({CISX_OP_CLEAR, 8'h00}, 1'b0);
        rd(CISX_OFF_WREG, "wclr w", 32'h0);
        rd(CISX_OFF_STATUS, "wclr st", 32'h4);
        // Bit test skip with the bit clear and set
        for (int i = 0; i < 4; i++) begin
            rnd();
            p = {1'b0, lf[11:0]};
            v = lf[7:0];
            v[lf[10:8]] = i[0];
            apb(1'b1, CISX_OFF_FDATA, {24'h0, v});
            apb(1'b1, CISX_OFF_PC, {19'h0, p});
            exec({CISX_OP_BTSS, lf[10:8], f}, 1'b0);
            rd(CISX_OFF_PC, "skip pc", {19'h0, p + 13'h1 + i[0]});
        end
        // Call with page bits from the latch
        rnd();
        lat = lf[7:0];
        p = lf[14:2];
        apb(1'b1, CISX_OFF_LATCH, {24'h0, lat});
        apb(1'b1, CISX_OFF_PC, {19'h0, p});
        apb(1'b0, CISX_OFF_STATUS, 32'h0);
        st = rv[7:0];
        exec({CISX_OP_CALL, lf[10:0]}, 1'b0);
        rd(CISX_OFF_PC, "call pc", {19'h0, lat[4:3], lf[10:0]});
        rd(CISX_OFF_STACK_TOP, "call top", {19'h0, p + 13'h1});
        rd(CISX_OFF_STATUS, "call st", {24'h0, st});
        // Watchdog clear after the counter has run
        apb(1'b1, CISX_OFF_STATUS, 32'h0);
        repeat (600) @(posedge i_clock);
        exec(CISX_WATCHDOG_CLR, 1'b0);
        apb(1'b0, CISX_OFF_WATCHDOG, 32'h0);
        chk("watchdog count", 32'h0, {24'h0, rv[7:0]});
        chk("watchdog presc", 32'h1, {31'h0, rv[15:8] < 8'h10});
        rd(CISX_OFF_STATUS, "watchdog st", 32'h18);
        // Interrupt entry keeps working and status registers
        apb(1'b1, CISX_OFF_WREG, 32'h77);
        apb(1'b1, CISX_OFF_STATUS, 32'h04);
        apb(1'b1, CISX_OFF_PC, {19'h0, p});
        exec(14'h0, 1'b1);
        rd(CISX_OFF_PC, "irq pc", {19'h0, CISX_IRQ_VECTOR});
        rd(CISX_OFF_STACK_TOP, "irq top", {19'h0, p});
        rd(CISX_OFF_WREG, "irq w", 32'h77);
        rd(CISX_OFF_STATUS, "irq st", 32'h04);
        tally_and_finish();
    end
endmodule // testbench
